// file: rtl/lapd_global_config_loader.sv
// Global configuration block constants loader with AHB-Lite register slave
//
// Contract
// - Frame reject send follows option one bit 1
// - System mode one: 16 links via CAM
// - System mode zero: 8192 links, external table
// - Option two bit 4 selects protocol variant
// - Flip option inverts received DLCI lsb
// - Link statistics enable per-link down counters
// - Retransmit statistics enable up counter
// - Multibuffer chains buffers, nonprotocol links only
// - Multibuffer off: single buffer per frame
// - Copy each table pointer at init
// - Tail offset is (length minus 5) times 2
// - Internal queue 32 or 48 words
// - Interrupt queue length is 14 bits
// - Interrupt tail is start plus 4n minus 2
// - Pools 0-15 internal, table starts at 16
// - Constants read only on init command
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "lapd_cfg_defines.svh"

module lapd_global_config_loader (
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp,
  output logic                     mem_req,
  output logic [31:0]              mem_addr,
  input  wire logic                mem_ack,
  input  wire logic [31:0]         mem_rdata,
  output lapd_cfg_pkg::cfg_s       cfg
);
  import lapd_cfg_pkg::*;

  // Host-visible control state
  logic [31:0] gcb_base_ff;
  logic        busy_ff;
  logic        done_ff;
  logic        init_pulse;
  // Fetch sequencer
  fetch_e      state_ff;
  logic [3:0]  word_idx_ff;
  logic        mem_req_ff;
  logic [31:0] mem_addr_ff;
  logic        last_word;
  // Shadow set filled during a fetch
  logic [15:0] sh_opt1_ff;
  logic [15:0] sh_opt2_ff;
  logic [31:0] sh_match_ff;
  logic [31:0] sh_l2_ptr_ff;
  logic [15:0] sh_l2_len_ff;
  logic [31:0] sh_timer_ff;
  logic [31:0] sh_llt_ff;
  logic [31:0] sh_intq_ptr_ff;
  logic [13:0] sh_intq_len_ff;
  logic [31:0] sh_pool_ff;
  logic        commit_ff;
  cfg_s        cfg_ff;
  cfg_s        nxt_cfg;
  logic [15:0] cur_opt1_ff;
  logic [15:0] cur_opt2_ff;
  // Register bus side
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        addr_valid;
  logic [31:0] nxt_rdata;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  logic        hresp_ff;
  logic        word_landed;
  logic        wr_cmd_hit;
  logic        wr_base_hit;
  logic [31:0] nxt_mem_addr;

  // Zero wait state slave, always OKAY; kept in flops like every other port
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  assign hreadyout  = hreadyout_ff;
  assign hresp      = hresp_ff;
  assign hrdata     = hrdata_ff;
  assign addr_valid = hsel && hready && htrans[1];

  // Write address phase is captured, data written next cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_valid && hwrite;
      if (addr_valid) begin
        wr_addr_ff <= haddr[7:0];
      end
    end
  end

  // Write targets decoded from the captured address phase
  assign wr_cmd_hit  = wr_pend_ff && (wr_addr_ff == `REG_CMD);
  assign wr_base_hit = wr_pend_ff && (wr_addr_ff == `REG_GCB_BASE);

  // Init command is a single-cycle strobe; ignored while a fetch runs
  assign init_pulse = wr_cmd_hit && hwdata[`CMD_INIT_BIT] && !busy_ff;

  // Base of the block in shared memory
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gcb_base_ff <= `GCB_BASE_RST;
    end else if (wr_base_hit && !busy_ff) begin // Base frozen mid fetch
      gcb_base_ff <= hwdata;
    end
  end

  // Read data decoded in address phase, held for the data phase
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (haddr[7:0])
      `REG_STATUS:    nxt_rdata = {30'h0000_0000, done_ff, busy_ff};
      `REG_GCB_BASE:  nxt_rdata = gcb_base_ff;
      `REG_OPT1:      nxt_rdata = {16'h0000, cur_opt1_ff};
      `REG_OPT2:      nxt_rdata = {16'h0000, cur_opt2_ff};
      `REG_MATCH_PTR: nxt_rdata = cfg_ff.match_table_ptr;
      `REG_L2_PTR:    nxt_rdata = cfg_ff.l2_queue_ptr;
      `REG_L2_TAIL:   nxt_rdata = {16'h0000, cfg_ff.queue_tail_offset};
      `REG_TIMER_PTR: nxt_rdata = cfg_ff.timer_table_ptr;
      `REG_LLT_PTR:   nxt_rdata = cfg_ff.link_lookup_table_ptr;
      `REG_INTQ_PTR:  nxt_rdata = cfg_ff.intq_ptr;
      `REG_INTQ_TAIL: nxt_rdata = cfg_ff.intq_tail_ptr;
      `REG_POOL_PTR:  nxt_rdata = cfg_ff.pool_table_ptr;
      default:        nxt_rdata = 32'h0000_0000; // Unmapped reads as zero
    endcase
  end

  // Captured at the address phase so data stands through the data phase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (addr_valid && !hwrite) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // Fetch sequencer: one word request at a time over the memory port
  assign last_word = (word_idx_ff == (`CONST_WORDS - 4'h1));
  // A word lands on the edge where the far side acknowledges
  assign word_landed = (state_ff == ST_WAIT) && mem_ack;
  // Byte address of the word asked for next; words are four bytes apart
  assign nxt_mem_addr = gcb_base_ff + {26'h000_0000, word_idx_ff, 2'b00};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff    <= ST_IDLE;
      word_idx_ff <= 4'h0;
      mem_req_ff  <= 1'b0;
      mem_addr_ff <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (init_pulse) begin
            state_ff    <= ST_REQ;
            word_idx_ff <= 4'h0;
          end
        end
        ST_REQ: begin
          mem_req_ff  <= 1'b1;
          // Address moves with the request, never a stale word index
          mem_addr_ff <= nxt_mem_addr;
          state_ff    <= ST_WAIT;
        end
        ST_WAIT: begin
          // No limit on wait cycles; the far side sets the pace
          if (mem_ack) begin
            mem_req_ff <= 1'b0;
            if (last_word) begin
              state_ff <= ST_IDLE;
            end else begin
              word_idx_ff <= word_idx_ff + 4'h1;
              state_ff    <= ST_REQ;
            end
          end
        end
        default: state_ff <= ST_IDLE; // Unused code recovers to idle
      endcase
    end
  end

  // Fetch port straight from its flops
  assign mem_req  = mem_req_ff;
  assign mem_addr = mem_addr_ff;

  // Busy until commit; done sticks until the next init
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      commit_ff <= 1'b0;
    end else begin
      commit_ff <= word_landed && last_word;
      if (init_pulse) begin
        busy_ff <= 1'b1;
        done_ff <= 1'b0;
      end else if (commit_ff) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end
  end

  // Shadow copies fill word by word; live settings stay untouched meanwhile
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_opt1_ff     <= 16'h0000;
      sh_opt2_ff     <= 16'h0000;
      sh_match_ff    <= 32'h0000_0000;
      sh_l2_ptr_ff   <= 32'h0000_0000;
      sh_l2_len_ff   <= 16'h0000;
      sh_timer_ff    <= 32'h0000_0000;
      sh_llt_ff      <= 32'h0000_0000;
      sh_intq_ptr_ff <= 32'h0000_0000;
      sh_intq_len_ff <= 14'h0000;
      sh_pool_ff     <= 32'h0000_0000;
    end else if (word_landed) begin
      unique case (word_idx_ff)
        `W_OPTS: begin
          sh_opt1_ff <= mem_rdata[31:16];
          sh_opt2_ff <= mem_rdata[15:0];
        end
        `W_MATCH:    sh_match_ff    <= mem_rdata;
        `W_L2_PTR:   sh_l2_ptr_ff   <= mem_rdata;
        `W_L2_LEN:   sh_l2_len_ff   <= mem_rdata[31:16];
        `W_TIMER:    sh_timer_ff    <= mem_rdata;
        `W_LLT:      sh_llt_ff      <= mem_rdata;
        `W_INTQ_PTR: sh_intq_ptr_ff <= mem_rdata;
        // Top two bits dropped so a stray host value cannot overflow the count
        `W_INTQ_LEN: sh_intq_len_ff <= mem_rdata[16 +: `INTQ_LEN_BITS];
        `W_POOL:     sh_pool_ff     <= mem_rdata;
        default:     ;                            // Reserved words skipped
      endcase
    end
  end

  // Decode options and derive tails from the complete shadow set
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_cfg.reject_frame_send_enable = sh_opt1_ff[`OPT1_FRMR_TX];
    nxt_cfg.cam_lookup_enable        = sh_opt1_ff[`OPT1_SYS_MODE];
    nxt_cfg.ext_match_table_enable   = !sh_opt1_ff[`OPT1_SYS_MODE];
    nxt_cfg.link_limit = sh_opt1_ff[`OPT1_SYS_MODE] ? `LINKS_ONCHIP : `LINKS_EXPAND;
    nxt_cfg.l2_internal_words = sh_opt1_ff[`OPT1_SYS_MODE] ? `L2_INT_ONCHIP : `L2_INT_EXPAND;
    nxt_cfg.protocol_variant_select  = sh_opt2_ff[`OPT2_VARIANT];
    nxt_cfg.address_flip_enable      = sh_opt2_ff[`OPT2_FLIP];
    nxt_cfg.link_stats_enable        = sh_opt2_ff[`OPT2_LINK_STAT];
    nxt_cfg.retx_stats_enable        = sh_opt2_ff[`OPT2_RETX_STAT];
    nxt_cfg.multibuffer_enable       = sh_opt2_ff[`OPT2_MULTIBUF];
    nxt_cfg.first_ext_pool           = `FIRST_EXT_POOL;
    nxt_cfg.match_table_ptr          = sh_match_ff;
    nxt_cfg.l2_queue_ptr             = sh_l2_ptr_ff;
    nxt_cfg.timer_table_ptr          = sh_timer_ff;
    nxt_cfg.link_lookup_table_ptr    = sh_llt_ff;
    nxt_cfg.intq_ptr                 = sh_intq_ptr_ff;
    nxt_cfg.pool_table_ptr           = sh_pool_ff;
    // Wraps modulo 2^16 if the host gives fewer than 5 words
    nxt_cfg.queue_tail_offset = {sh_l2_len_ff[14:0] - 15'(`L2_LEN_BIAS), 1'b0};
    nxt_cfg.intq_tail_ptr = sh_intq_ptr_ff + {16'h0000, sh_intq_len_ff, 2'b00} - `INTQ_TAIL_BIAS;
  end

  // All live settings switch in one edge after the last word lands
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff      <= '0;
      cur_opt1_ff <= 16'h0000;
      cur_opt2_ff <= 16'h0000;
    end else if (commit_ff) begin
      cfg_ff      <= nxt_cfg;
      cur_opt1_ff <= sh_opt1_ff;
      cur_opt2_ff <= sh_opt2_ff;
    end
  end

  // Settings reach the datapath only from the commit flops
  assign cfg = cfg_ff;
endmodule : lapd_global_config_loader

// file: rtl/lapd_cfg_defines.svh
// Offsets, field positions and counts for the configuration loader
`ifndef LAPD_CFG_DEFINES_SVH
`define LAPD_CFG_DEFINES_SVH
// Register byte addresses
`define REG_CMD        8'h00
`define REG_STATUS     8'h04
`define REG_GCB_BASE   8'h08
`define REG_OPT1       8'h0C
`define REG_OPT2       8'h10
`define REG_MATCH_PTR  8'h14
`define REG_L2_PTR     8'h18
`define REG_L2_TAIL    8'h1C
`define REG_TIMER_PTR  8'h20
`define REG_LLT_PTR    8'h24
`define REG_INTQ_PTR   8'h28
`define REG_INTQ_TAIL  8'h2C
`define REG_POOL_PTR   8'h30
`define CMD_INIT_BIT   0
`define STAT_BUSY_BIT  0
`define STAT_DONE_BIT  1
// Constants area: 48 bytes, fetched as 12 words
`define CONST_WORDS    4'hC
`define W_OPTS         4'h0
`define W_MATCH        4'h1
`define W_L2_PTR       4'h2
`define W_L2_LEN       4'h3
`define W_TIMER        4'h4
`define W_LLT          4'h5
`define W_INTQ_PTR     4'h6
`define W_INTQ_LEN     4'h7
`define W_POOL         4'h8
// Option word field positions
`define OPT1_SYS_MODE  0
`define OPT1_FRMR_TX   1
`define OPT2_MULTIBUF  0
`define OPT2_RETX_STAT 1
`define OPT2_LINK_STAT 2
`define OPT2_FLIP      3
`define OPT2_VARIANT   4
// Derivation constants
`define L2_LEN_BIAS    16'h0005
`define INTQ_LEN_BITS  14
`define INTQ_TAIL_BIAS 32'h0000_0002
`define LINKS_ONCHIP   14'h0010
`define LINKS_EXPAND   14'h2000
`define L2_INT_ONCHIP  6'h20
`define L2_INT_EXPAND  6'h30
`define FIRST_EXT_POOL 5'h10
`define GCB_BASE_RST   32'h0000_0000
`endif

// file: rtl/lapd_cfg_pkg.sv
// Types shared by the configuration loader
package lapd_cfg_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} fetch_e;
  typedef struct packed {
    logic        reject_frame_send_enable;
    logic        cam_lookup_enable;
    logic        ext_match_table_enable;
    logic        protocol_variant_select;
    logic        address_flip_enable;
    logic        link_stats_enable;
    logic        retx_stats_enable;
    logic        multibuffer_enable;
    logic [13:0] link_limit;
    logic [5:0]  l2_internal_words;
    logic [4:0]  first_ext_pool;
    logic [31:0] match_table_ptr;
    logic [31:0] l2_queue_ptr;
    logic [15:0] queue_tail_offset;
    logic [31:0] timer_table_ptr;
    logic [31:0] link_lookup_table_ptr;
    logic [31:0] intq_ptr;
    logic [31:0] intq_tail_ptr;
    logic [31:0] pool_table_ptr;
  } cfg_s;
endpackage : lapd_cfg_pkg

// file: test/lapd_cfg_chk.sv
// Concurrent checks on the loader's bus, fetch and configuration ports
module lapd_cfg_chk (
  input wire logic               sys_clk,
  input wire logic               reset_n,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               mem_req,
  input wire logic [31:0]        mem_addr,
  input wire logic               mem_ack,
  input wire lapd_cfg_pkg::cfg_s cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  import lapd_cfg_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // One constants word answered by memory
  sequence word_done;
    mem_req && mem_ack;
  endsequence
  // Next word request after the idle cycle
  sequence next_word;
    word_done ##2 mem_req;
  endsequence
  zero_wait_a: assert property (hreadyout && !hresp) else $error("bus wait or error");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("fetch dropped");
  req_drop_a: assert property (word_done |=> !mem_req) else $error("request held after ack");
  addr_step_a: assert property (next_word |-> mem_addr == $past(mem_addr, 2) + 32'h4) else $error("bad step");
  cfg_hold_a: assert property (mem_req |=> $stable(cfg)) else $error("config moved mid fetch");
  onchip_mode_a: assert property (cfg.cam_lookup_enable |-> cfg.link_limit == 14'h0010
    && !cfg.ext_match_table_enable && cfg.l2_internal_words == 6'h20) else $error("on-chip limits wrong");
  expand_mode_a: assert property (cfg.ext_match_table_enable |-> cfg.link_limit == 14'h2000
    && !cfg.cam_lookup_enable && cfg.l2_internal_words == 6'h30) else $error("expanded limits wrong");
  pool_base_a: assert property ($changed(cfg) |-> cfg.first_ext_pool == 5'h10) else $error("pool base wrong");
  commit_late_a: assert property ($changed(cfg) |-> $past(mem_ack, 2) || $past(mem_ack, 3))
    else $error("commit not after last word");
endmodule : lapd_cfg_chk

bind lapd_global_config_loader lapd_cfg_chk chk (.sys_clk(sys_clk), .reset_n(reset_n), .hreadyout(hreadyout),
  .hresp(hresp), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .cfg(cfg));

// file: test/cfg_mem_model.sv
// Shared-memory model of the host's constants area with random answer delay
module cfg_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Loaded by the bench; unused option and length bits kept zero
  logic [31:0] words [16];
  // Start of the constants area in shared memory, set by the bench
  logic [31:0] base;
  logic [1:0]  wait_ff;
  logic        done_ff;
  // One ack per request; data line toggles when not answering so stale data never matches
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_ff <= 2'h0;
      done_ff <= 1'b0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!mem_req) begin
        done_ff <= 1'b0;
      end else if (!done_ff && wait_ff == 2'h0) begin
        mem_ack <= 1'b1;
        // Host zeroed every other area, so a stray address reads zero
        mem_rdata <= (mem_addr[31:6] == base[31:6]) ? words[mem_addr[5:2]] : 32'h0;
        done_ff <= 1'b1;
        wait_ff <= 2'($urandom_range(3));
      end else if (!done_ff) begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule : cfg_mem_model

// file: test/tb.sv
// Self-checking bench for the configuration loader
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lapd_cfg_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, mem_req, mem_ack;
  logic [31:0] hrdata, mem_addr, mem_rdata, rd, base;
  logic [31:0] w [16];
  cfg_s        cfg, exp;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          n;
  lapd_global_config_loader dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .cfg(cfg));
  cfg_mem_model mem (.sys_clk(sys_clk), .reset_n(reset_n), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task automatic check(input logic [511:0] seen, input logic [511:0] want);
    n_compared++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, want);
    end
  endtask : check
  // Bounded wait for hready at a rising edge
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      results();
    end
  endtask : wait_ready
  // One AHB-Lite single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : bus
  // Configuration implied by the constants words
  function automatic cfg_s want_cfg();
    cfg_s c;
    c = '0;
    c.reject_frame_send_enable = w[0][17];
    c.cam_lookup_enable = w[0][16];
    c.ext_match_table_enable = !w[0][16];
    c.protocol_variant_select = w[0][4];
    c.address_flip_enable = w[0][3];
    c.link_stats_enable = w[0][2];
    c.retx_stats_enable = w[0][1];
    c.multibuffer_enable = w[0][0];
    c.link_limit = w[0][16] ? 14'h0010 : 14'h2000;
    c.l2_internal_words = w[0][16] ? 6'h20 : 6'h30;
    c.first_ext_pool = 5'h10;
    c.match_table_ptr = w[1];
    c.l2_queue_ptr = w[2];
    c.queue_tail_offset = 16'((w[3][31:16] - 16'h0005) * 2);
    c.timer_table_ptr = w[4];
    c.link_lookup_table_ptr = w[5];
    c.intq_ptr = w[6];
    c.intq_tail_ptr = w[6] + 32'(w[7][29:16]) * 4 - 32'h2;
    c.pool_table_ptr = w[8];
    return c;
  endfunction : want_cfg
  // Reset values, refused accesses, then repeated loads with corners first
  initial begin
    void'($urandom(32'hFA7C));
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      foreach (w[k]) w[k] = $urandom();
      w[0] = {14'h0, 2'($urandom()), 11'h0, 5'($urandom())};
      if (i < 2) w[0] = i ? 32'h0 : 32'h0003_001F;
      w[3][31] = 1'b0;
      if (w[3][30:16] < 15'h0080) w[3][30:16] = 15'h0080;
      w[7][31:30] = 2'b00;
      if (i < 2) w[3][30:16] = i ? 15'h7FFF : 15'h0;
      if (i < 2) w[7][29:16] = i ? 14'h3FFF : 14'h0;
      base = {26'($urandom()), 6'h0};
      mem.words = w;
      mem.base = base;
      exp = want_cfg();
      bus(1'b1, 8'h08, base);
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b1, 8'h08, ~base);
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b0, 8'h04, 32'h0);
      check(rd, 32'h1);
      n = 0;
      do begin
        bus(1'b0, 8'h04, 32'h0);
        n++;
      end while (rd[0] !== 1'b0 && n < 200);
      if (n >= 200) begin
        error_cnt++;
        results();
      end
      check(rd, 32'h2);
      check(cfg, exp);
      bus(1'b0, 8'h08, 32'h0);
      check(rd, base);
      bus(1'b0, 8'h1C, 32'h0);
      check(rd, {16'h0, exp.queue_tail_offset});
      bus(1'b0, 8'h2C, 32'h0);
      check(rd, exp.intq_tail_ptr);
      bus(1'b0, 8'h30, 32'h0);
      check(rd, w[8]);
      bus(1'b0, 8'h0C, 32'h0);
      check(rd, {16'h0, w[0][31:16]});
      bus(1'b0, 8'h10, 32'h0);
      check(rd, {16'h0, w[0][15:0]});
      bus(1'b0, 8'h14, 32'h0);
      check(rd, w[1]);
      bus(1'b0, 8'h18, 32'h0);
      check(rd, w[2]);
      bus(1'b0, 8'h20, 32'h0);
      check(rd, w[4]);
      bus(1'b0, 8'h24, 32'h0);
      check(rd, w[5]);
      bus(1'b0, 8'h28, 32'h0);
      check(rd, w[6]);
    end
    results();
  end
endmodule : tb
